// ---- include/pss_pkg.sv ----
// ****************************************************************
// Shared constants and types of the peripheral share switch control
// ****************************************************************
package pss_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_HZ        = 10_000_000;
    localparam int BLANK_TIME_MS = 100;
    localparam int BLANK_CYCLES  = BLANK_TIME_MS * (CLK_HZ / 1000);
    localparam int POST_TIME_US  = 2000;
    localparam int POST_CYCLES   = POST_TIME_US * (CLK_HZ / 1_000_000);

    // ************************************************************
    // Variant defaults
    // ************************************************************
    localparam int NHOST_DEF = 4;
    localparam int NDISP_DEF = 1;

    // ************************************************************
    // Register port layout
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] REG_EDID   = 4'h2;
    localparam logic [ADDR_W-1:0] REG_LOG    = 4'h3;

    // Control fields and reset value
    localparam int                CTRL_DP_BIT    = 0;
    localparam int                CTRL_GUARD_BIT = 1;
    localparam logic [DATA_W-1:0] CTRL_MASK      = 8'h03;
    localparam logic [DATA_W-1:0] CTRL_RST       = 8'h03;

    // Status fields
    localparam int ST_HOST_LSB      = 0;
    localparam int ST_POST_FAIL_BIT = 4;
    localparam int ST_TAMPER_BIT    = 5;
    localparam int ST_REJECT_BIT    = 6;
    localparam int ST_BLANK_BIT     = 7;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0]
    {
        MODE_POST,
        MODE_EDID,
        MODE_RUN,
        MODE_FAIL
    } pss_mode_t;

    typedef struct packed
    {
        logic       valid;
        logic [7:0] code;
    } pss_key_t;

    typedef struct packed
    {
        logic       valid;
        logic [7:0] data;
    } pss_mouse_t;

    // One enable per video sub-protocol; a low bit blocks it
    typedef struct packed
    {
        logic cec;
        logic edid_h2d;
        logic copy_prot;
        logic mccs;
        logic arc;
        logic heac;
        logic hec;
        logic edid_d2h;
        logic hpd;
        logic link_train;
        logic video_fwd;
    } pss_vid_pass_t;

endpackage

// ---- rtl/pss_switch_ctrl.sv ----
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none

module pss_switch_ctrl
#(
    parameter int NHOST     = pss_pkg::NHOST_DEF,
    parameter int NDISP     = pss_pkg::NDISP_DEF,
    parameter int POST_CNT  = pss_pkg::POST_CYCLES,
    parameter int BLANK_CNT = pss_pkg::BLANK_CYCLES
)
(
    // Clock and reset
    input  wire logic                          CLK,
    input  wire logic                          RESET_N,
    // Register port
    input  wire logic [pss_pkg::ADDR_W-1:0]    REG_ADDR,
    input  wire logic [pss_pkg::DATA_W-1:0]    REG_WDATA,
    input  wire logic                          REG_WR,
    input  wire logic                          REG_RD,
    output logic      [pss_pkg::DATA_W-1:0]    REG_RDATA,
    // Front panel buttons and peripheral guard
    input  wire logic [NHOST-1:0]              BTN_N,
    input  wire logic                          GUARD_REQ,
    input  wire logic [$clog2(NHOST)-1:0]      GUARD_HOST,
    // Anti-tamper sense
    input  wire logic                          TAMPER_N,
    // Display identification fetch
    output logic      [NDISP-1:0]              EDID_REQ,
    input  wire logic [NDISP-1:0]              EDID_DONE,
    // Keyboard and mouse
    input  wire logic                          KM_ENUM,
    input  wire logic                          KM_DEV_AUTH,
    input  wire pss_pkg::pss_key_t             KBD_IN,
    input  wire pss_pkg::pss_mouse_t           MOUSE_IN,
    output var  pss_pkg::pss_key_t             KBD_OUT,
    output var  pss_pkg::pss_mouse_t           MOUSE_OUT,
    output logic      [NHOST-1:0]              KBD_HOST_SEL,
    output logic      [NHOST-1:0]              MOUSE_HOST_SEL,
    // Video
    output logic      [NHOST-1:0]              VID_HOST_SEL,
    output var  pss_pkg::pss_vid_pass_t        VID_PASS,
    // Audio
    input  wire logic                          AUD_DEV_AUTH,
    output logic                               AUD_PWR_EN,
    output logic      [NHOST-1:0]              AUD_HOST_SEL,
    // Indicators
    output logic      [NHOST-1:0]              LED_HOST,
    output logic      [$clog2(NHOST)-1:0]      OSD_HOST,
    output logic                               OSD_ON,
    output logic                               FAIL_LED,
    output logic                               BUZZER,
    output logic                               REJECT_LED
);
    import pss_pkg::*;

    // ************************************************************
    // Derived sizes and parameter checks
    // ************************************************************
    localparam int HW   = $clog2(NHOST);
    localparam int MAXC = (POST_CNT > BLANK_CNT) ? POST_CNT : BLANK_CNT;
    localparam int TW   = $clog2(MAXC + 1);

    // Host field in status is three bits wide, so at most eight hosts
    if (NHOST < 2 || NHOST > 8 || NDISP < 1 || NDISP > 2 || POST_CNT < 1 || BLANK_CNT < 1)
    begin
        $error("pss_switch_ctrl: unsupported parameter value");
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed
    {
        pss_mode_t        mode;
        logic [HW-1:0]    sel;
        logic [TW-1:0]    timer;
        logic             blank;
        logic             post_fail;
        logic             tamper_fail;
        logic             reject;
        logic [NDISP-1:0] edid_req;
        logic [NDISP-1:0] edid_got;
        logic [7:0]       ctrl;
        logic [7:0]       rdata;
        logic [7:0]       log_cnt;
        logic [NHOST-1:0] btn_prev;
        pss_key_t         kbd;
        pss_mouse_t       mouse;
        logic [NHOST-1:0] km_sel;
        logic [NHOST-1:0] vid_sel;
        logic [NHOST-1:0] aud_sel;
        logic [NHOST-1:0] led;
        logic [HW-1:0]    osd_host;
        logic             osd_on;
        pss_vid_pass_t    vpass;
        logic             aud_pwr;
        logic             fail_led;
        logic             buzzer;
        logic             reject_led;
    } pss_state_t;

    pss_state_t       s;
    pss_state_t       n;

    logic [NHOST:0]   pin_q;
    logic [NHOST-1:0] btn_p;
    logic             tamper_q;
    logic [NHOST-1:0] press;
    logic             sw_req;
    logic [HW-1:0]    sw_host;
    logic             switching;
    logic             run;
    logic             km_ok;

    // ************************************************************
    // Pin synchronisers for buttons and tamper sense
    // ************************************************************
    pss_sync3
    #(
        .W   (NHOST + 1),
        .RST ('1)
    )
    u_sync
    (
        .CLK     (CLK),
        .RESET_N (RESET_N),
        .D_IN    ({TAMPER_N, BTN_N}),
        .Q_OUT   (pin_q)
    );

    assign btn_p    = ~pin_q[NHOST-1:0];
    assign tamper_q = pin_q[NHOST];

    // One-hot decode of a host number
    function automatic logic [NHOST-1:0] onehot(input logic [HW-1:0] h);
        onehot    = '0;
        onehot[h] = 1'b1;
    endfunction

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        n          = s;
        n.edid_req = '0;
        n.rdata    = '0;
        sw_req     = 1'b0;
        sw_host    = s.sel;
        switching  = 1'b0;
        press      = btn_p & ~s.btn_prev;
        n.btn_prev = btn_p;

        // Software may steer path type and guard enable only
        if (REG_WR && REG_ADDR == REG_CTRL)
        begin
            n.ctrl = REG_WDATA & CTRL_MASK;
        end

        // Read decode exposes status, never keyboard or mouse data
        if (REG_RD)
        begin
            case (REG_ADDR)
                REG_CTRL:
                begin
                    n.rdata = s.ctrl;
                end
                REG_STATUS:
                begin
                    n.rdata[ST_HOST_LSB +: HW]  = s.sel;
                    n.rdata[ST_POST_FAIL_BIT]   = s.post_fail;
                    n.rdata[ST_TAMPER_BIT]      = s.tamper_fail;
                    n.rdata[ST_REJECT_BIT]      = s.reject;
                    n.rdata[ST_BLANK_BIT]       = s.blank;
                end
                REG_EDID:
                begin
                    n.rdata[NDISP-1:0] = s.edid_got;
                end
                REG_LOG:
                begin
                    n.rdata = s.log_cnt;
                end
                default:
                begin
                    n.rdata = '0;
                end
            endcase
        end

        // Each enumeration re-judges the peripheral
        if (KM_ENUM)
        begin
            n.reject = ~KM_DEV_AUTH;
        end

        // Mode sequence: self-test, identification fetch, run, fail
        case (s.mode)
            MODE_POST:
            begin
                n.timer = s.timer + TW'(1);
                if (|btn_p)
                begin
                    n.post_fail = 1'b1;
                end
                if (!tamper_q)
                begin
                    n.post_fail   = 1'b1;
                    n.tamper_fail = 1'b1;
                end
                if (n.post_fail)
                begin
                    n.mode = MODE_FAIL;
                end
                else if (s.timer == TW'(POST_CNT - 1))
                begin
                    n.mode     = MODE_EDID;
                    n.timer    = '0;
                    n.edid_req = ~s.edid_got;
                end
            end
            MODE_EDID:
            begin
                n.edid_got = s.edid_got | EDID_DONE;
                if (!tamper_q)
                begin
                    n.tamper_fail = 1'b1;
                    n.mode        = MODE_FAIL;
                end
                else if (&n.edid_got)
                begin
                    n.mode = MODE_RUN;
                end
            end
            MODE_RUN:
            begin
                if (!tamper_q)
                begin
                    n.tamper_fail = 1'b1;
                    n.mode        = MODE_FAIL;
                end
                else
                begin
                    // Only buttons and guard are sources; lowest button wins
                    for (int i = NHOST - 1; i >= 0; i--)
                    begin
                        if (press[i])
                        begin
                            sw_req  = 1'b1;
                            sw_host = HW'(i);
                        end
                    end
                    if (!sw_req && GUARD_REQ && s.ctrl[CTRL_GUARD_BIT] && GUARD_HOST < NHOST)
                    begin
                        sw_req  = 1'b1;
                        sw_host = GUARD_HOST;
                    end
                    if (sw_req && sw_host != s.sel)
                    begin
                        switching = 1'b1;
                        n.sel     = sw_host;
                        n.blank   = 1'b1;
                        n.timer   = '0;
                        n.log_cnt = s.log_cnt + 8'h01;
                    end
                    else if (s.blank)
                    begin
                        n.timer = s.timer + TW'(1);
                        if (s.timer == TW'(BLANK_CNT - 1))
                        begin
                            n.blank = 1'b0;
                            n.timer = '0;
                        end
                    end
                end
            end
            MODE_FAIL:
            begin
                // Held until reset; nothing but RESET_N leaves this mode
                n.mode = MODE_FAIL;
            end
            default:
            begin
                n.mode = MODE_FAIL;
            end
        endcase

        // All paths and indicators decoded from the one next selection
        run        = (n.mode == MODE_RUN);
        km_ok      = run && !n.reject;
        n.km_sel   = km_ok ? onehot(n.sel) : '0;
        n.vid_sel  = run ? onehot(n.sel) : '0;
        n.aud_sel  = run ? onehot(n.sel) : '0;
        n.led      = run ? onehot(n.sel) : '0;
        n.osd_host = n.sel;
        n.osd_on   = run;

        // Keyboard data held one cycle only and wiped on every switch
        if (km_ok && !n.blank && !switching && KBD_IN.valid)
        begin
            n.kbd = KBD_IN;
        end
        else
        begin
            n.kbd = '0;
        end

        // Mouse follows the keyboard's host, no blanking
        if (km_ok && !switching && MOUSE_IN.valid)
        begin
            n.mouse = MOUSE_IN;
        end
        else
        begin
            n.mouse = '0;
        end

        // Sub-protocol filter: blocked enables stay low in every mode
        n.vpass = '0;
        if (run)
        begin
            n.vpass.edid_d2h   = 1'b1;
            n.vpass.hpd        = 1'b1;
            n.vpass.link_train = n.ctrl[CTRL_DP_BIT];
            n.vpass.video_fwd  = 1'b1;
        end

        // Audio power and failure indications
        n.aud_pwr    = run && AUD_DEV_AUTH;
        n.fail_led   = (n.mode == MODE_FAIL);
        n.buzzer     = (n.mode == MODE_FAIL);
        n.reject_led = n.reject;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            s      <= '0;
            s.mode <= MODE_POST;
            s.sel  <= '0;
            s.ctrl <= CTRL_RST;
        end
        else
        begin
            s <= n;
        end
    end

    // ************************************************************
    // Outputs, each straight from a state flip-flop
    // ************************************************************
    assign REG_RDATA      = s.rdata;
    assign EDID_REQ       = s.edid_req;
    assign KBD_OUT        = s.kbd;
    assign MOUSE_OUT      = s.mouse;
    assign KBD_HOST_SEL   = s.km_sel;
    assign MOUSE_HOST_SEL = s.km_sel;
    assign VID_HOST_SEL   = s.vid_sel;
    assign VID_PASS       = s.vpass;
    assign AUD_PWR_EN     = s.aud_pwr;
    assign AUD_HOST_SEL   = s.aud_sel;
    assign LED_HOST       = s.led;
    assign OSD_HOST       = s.osd_host;
    assign OSD_ON         = s.osd_on;
    assign FAIL_LED       = s.fail_led;
    assign BUZZER         = s.buzzer;
    assign REJECT_LED     = s.reject_led;

endmodule

`default_nettype wire

// ---- rtl/pss_sync3.sv ----
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Three-stage pin synchroniser with agreement filter
// ****************************************************************
module pss_sync3
#(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '1
)
(
    // Clock and reset
    input  wire logic         CLK,
    input  wire logic         RESET_N,
    // Pins and filtered levels
    input  wire logic [W-1:0] D_IN,
    output logic      [W-1:0] Q_OUT
);

    typedef struct packed
    {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } pss_sync_t;

    pss_sync_t s;
    pss_sync_t n;

    // Only the second stage looks at the first; a bit moves once stages two and three agree
    always_comb
    begin
        n    = s;
        n.s1 = D_IN;
        n.s2 = s.s1;
        n.s3 = s.s2;
        n.q  = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.q);
    end

    // State register
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            s.s1 <= RST;
            s.s2 <= RST;
            s.s3 <= RST;
            s.q  <= RST;
        end
        else
        begin
            s <= n;
        end
    end

    assign Q_OUT = s.q;

endmodule

`default_nettype wire

// ---- test/pss_periph_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// Display side: answers identification fetches
// ****
module pss_periph_model
#(
    parameter int NDISP = 1
)
(
    // Clock and reset
    input wire logic         CLK,
    input wire logic         RESET_N,
    // Fetch handshake
    input wire logic [NDISP-1:0] EDID_REQ,
    input wire logic         SLOW,
    output logic [NDISP-1:0] EDID_DONE,
    output var int           FETCHES
);
    int wait_cnt;

    // Done comes after one or six cycles, then holds as a level
    always @(posedge CLK or negedge RESET_N)
        if (!RESET_N)
        begin
            EDID_DONE <= '0;
            FETCHES <= 0;
            wait_cnt <= 0;
        end
        else if (EDID_REQ != '0)
        begin
            wait_cnt <= SLOW ? 6 : 1;
            FETCHES <= FETCHES + 1;
        end
        else if (wait_cnt == 1)
        begin
            wait_cnt <= 0;
            EDID_DONE <= '1;
        end
        else if (wait_cnt > 1)
            wait_cnt <= wait_cnt - 1;
endmodule
`default_nettype wire

// ---- test/pss_switch_ctrl_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// Switch control checker
// ****
module pss_switch_ctrl_monitor
    import pss_pkg::*;
#(
    parameter int NHOST = 4,
    parameter int NDISP = 1
)
(
    // Clock and reset
    input wire logic                     CLK,
    input wire logic                     RESET_N,
    // Selections and indicators
    input wire logic [NHOST-1:0]         KBD_HOST_SEL,
    input wire logic [NHOST-1:0]         MOUSE_HOST_SEL,
    input wire logic [NHOST-1:0]         VID_HOST_SEL,
    input wire logic [NHOST-1:0]         LED_HOST,
    input wire logic [$clog2(NHOST)-1:0] OSD_HOST,
    input wire logic                     OSD_ON,
    input wire logic                     FAIL_LED,
    input wire logic                     BUZZER,
    input wire logic                     REJECT_LED,
    // Paths
    input wire logic                     AUD_DEV_AUTH,
    input wire logic                     AUD_PWR_EN,
    input wire logic [NDISP-1:0]         EDID_REQ,
    input wire pss_key_t                 KBD_OUT,
    input wire pss_vid_pass_t            VID_PASS
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    // Remembers a fetch; a second one would read stale displays
    logic fetched_reg;
    always_ff @(posedge CLK or negedge RESET_N)
        if (!RESET_N)
            fetched_reg <= 1'b0;
        else if (EDID_REQ != '0)
            fetched_reg <= 1'b1;

    // Host change in run, then a quiet keyboard
    sequence host_moved_s;
        OSD_ON && $past(OSD_ON) && $changed(LED_HOST);
    endsequence
    sequence kbd_quiet_s;
        (KBD_OUT.valid == 1'b0) [*8];
    endsequence

    tied_sel_a: assert property (KBD_HOST_SEL == MOUSE_HOST_SEL)
        else $error("keyboard and mouse hosts differ");
    one_select_a: assert property (OSD_ON |-> LED_HOST == (1 << OSD_HOST)
        && VID_HOST_SEL == LED_HOST) else $error("indicators disagree");
    vid_block_a: assert property (VID_PASS[10:4] == 7'h00)
        else $error("blocked video channel open");
    vid_allow_a: assert property (OSD_ON |-> VID_PASS.edid_d2h && VID_PASS.hpd
        && VID_PASS.video_fwd) else $error("allowed video channel shut");
    fail_quiet_a: assert property (FAIL_LED |-> BUZZER && !OSD_ON && !AUD_PWR_EN
        && VID_PASS == '0 && KBD_HOST_SEL == '0) else $error("path open in failure");
    fail_hold_a: assert property ($rose(FAIL_LED) |=> FAIL_LED [*8])
        else $error("failure state left");
    edid_once_a: assert property (EDID_REQ != '0 |-> !fetched_reg)
        else $error("display fetched twice");
    aud_pwr_a: assert property (AUD_PWR_EN |-> $past(AUD_DEV_AUTH))
        else $error("audio powered unauthorized");
    kbd_blank_a: assert property (host_moved_s |-> kbd_quiet_s)
        else $error("keyboard data after switch");
    reject_cut_a: assert property (REJECT_LED |-> KBD_HOST_SEL == '0
        && !KBD_OUT.valid) else $error("rejected device routed");
endmodule

bind pss_switch_ctrl pss_switch_ctrl_monitor #(.NHOST(NHOST), .NDISP(NDISP)) mon_u (
    .CLK(CLK), .RESET_N(RESET_N), .KBD_HOST_SEL(KBD_HOST_SEL),
    .MOUSE_HOST_SEL(MOUSE_HOST_SEL), .VID_HOST_SEL(VID_HOST_SEL), .LED_HOST(LED_HOST),
    .OSD_HOST(OSD_HOST), .OSD_ON(OSD_ON), .FAIL_LED(FAIL_LED), .BUZZER(BUZZER),
    .REJECT_LED(REJECT_LED), .AUD_DEV_AUTH(AUD_DEV_AUTH), .AUD_PWR_EN(AUD_PWR_EN),
    .EDID_REQ(EDID_REQ), .KBD_OUT(KBD_OUT), .VID_PASS(VID_PASS));
`default_nettype wire

// ---- test/test_pss_switch_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_pss_switch_ctrl;
    import pss_pkg::*;
    // ****
    // Bench signals
    // ****
    localparam int NH = 4;
    localparam int PC = 20;
    localparam int BC = 50;
    logic clk, rst_n, wr, rd, greq, tamp_n, en_v, en_ok, aud_ok, slow;
    logic edid_req, edid_done, osd_on, fail, buzz, rej, aud_pwr;
    logic [3:0] addr, btn_n, kbd_sel, mou_sel, vid_sel, aud_sel, led;
    logic [7:0] wdat, rdat;
    logic [1:0] ghost, osd;
    logic [31:0] seed;
    pss_key_t kin, kout;
    pss_mouse_t mse, mout;
    pss_vid_pass_t vpass;
    int errors, num_checks, fetches, i;
    logic [7:0] kq[$], rq[$], e;
    bit rd_d;

    // 10 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    pss_switch_ctrl #(.NHOST(NH), .NDISP(1), .POST_CNT(PC), .BLANK_CNT(BC)) dut_u (
        .CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdat), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdat), .BTN_N(btn_n), .GUARD_REQ(greq), .GUARD_HOST(ghost),
        .TAMPER_N(tamp_n), .EDID_REQ(edid_req), .EDID_DONE(edid_done), .KM_ENUM(en_v),
        .KM_DEV_AUTH(en_ok), .KBD_IN(kin), .MOUSE_IN(mse), .KBD_OUT(kout), .MOUSE_OUT(mout),
        .KBD_HOST_SEL(kbd_sel), .MOUSE_HOST_SEL(mou_sel), .VID_HOST_SEL(vid_sel),
        .VID_PASS(vpass), .AUD_DEV_AUTH(aud_ok), .AUD_PWR_EN(aud_pwr), .AUD_HOST_SEL(aud_sel),
        .LED_HOST(led), .OSD_HOST(osd), .OSD_ON(osd_on), .FAIL_LED(fail), .BUZZER(buzz),
        .REJECT_LED(rej));
    pss_periph_model #(.NDISP(1)) part_u (.CLK(clk), .RESET_N(rst_n), .EDID_REQ(edid_req),
        .SLOW(slow), .EDID_DONE(edid_done), .FETCHES(fetches));

    // ****
    // Tasks
    // ****
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Strobes drop a cycle before the next may rise
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        tick(1);
        wr <= 1'b0;
        tick(1);
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [7:0] x);
        addr <= a;
        rd <= 1'b1;
        rq.push_back(x);
        tick(1);
        rd <= 1'b0;
        tick(1);
    endtask
    task automatic key(input logic pass);
        seed = lfsr(seed);
        kin <= '{1'b1, seed[7:0]};
        if (pass)
        begin
            mse <= '{1'b1, ~seed[7:0]};
            kq.push_back(seed[7:0]);
        end
        tick(1);
        kin <= '0;
        mse <= '0;
        tick(1);
    endtask
    task automatic guard(input logic [1:0] h);
        ghost <= h;
        greq <= 1'b1;
        tick(1);
        greq <= 1'b0;
        tick(1);
    endtask
    task automatic give_verdict();
        check("kbd_left", 16'(kq.size()), 16'h0000);
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watcher: a result takes the oldest note; stray keys count as errors
    always @(posedge clk)
    begin
        if (rd_d)
            check("rdata", rdat, rq.pop_front());
        rd_d = (rd === 1'b1);
        if (kout.valid === 1'b1)
        begin
            check("kbd_note", 16'(kq.size() > 0), 16'h0001);
            e = (kq.size() > 0) ? kq.pop_front() : 8'h00;
            check("kbd", {kout.valid, kout.code}, {1'b1, e});
            check("mouse", mout, {1'b1, ~e});
        end
    end

    // Hang guard: far beyond the few hundred cycles of the run
    initial
    begin
        #3_000_000;
        errors++;
        give_verdict();
    end

    // ****
    // Main sequence
    // ****
    initial
    begin
        {rst_n, wr, rd, greq, en_v, ghost, addr, wdat} = '0;
        {tamp_n, en_ok, aud_ok, slow, btn_n} = {4'hF, 4'hF};
        kin = '0;
        mse = '0;
        seed = 32'h0000EEB8;
        errors = 0;
        num_checks = 0;
        tick(2);
        rst_n <= 1'b1;
        tick(1);
        reg_rd(REG_CTRL, CTRL_RST);
        reg_rd(4'hF, 8'h00);
        reg_wr(REG_STATUS, 8'hFF);
        reg_rd(REG_STATUS, 8'h00);
        for (i = 0; i < PC + 40 && osd_on !== 1'b1; i++) tick(1);
        check("led_boot", led, 4'b0001);
        reg_rd(REG_EDID, 8'h01);
        repeat (4) key(1'b1);
        guard(2'd2);
        check("sel", {kbd_sel, mou_sel, vid_sel, aud_sel}, 16'h4444);
        check("osd", osd, 2'd2);
        key(1'b0);
        reg_rd(REG_STATUS, 8'h82);
        tick(BC);
        key(1'b1);
        reg_rd(REG_LOG, 8'h01);
        reg_wr(REG_CTRL, 8'h00);
        tick(1);
        check("train_off", vpass.link_train, 1'b0);
        guard(2'd1);
        check("led_noguard", led, 4'b0100);
        reg_wr(REG_CTRL, 8'h01);
        tick(1);
        check("train", vpass.link_train, 1'b1);
        btn_n <= 4'b0111;
        for (i = 0; i < 10 && led !== 4'b1000; i++) tick(1);
        check("btn", {kbd_sel, mou_sel, aud_sel}, 12'h888);
        btn_n <= 4'hF;
        tick(BC + 5);
        en_ok <= 1'b0;
        en_v <= 1'b1;
        tick(1);
        en_v <= 1'b0;
        tick(1);
        check("reject", rej, 1'b1);
        key(1'b0);
        en_ok <= 1'b1;
        en_v <= 1'b1;
        tick(1);
        en_v <= 1'b0;
        tick(1);
        key(1'b1);
        aud_ok <= 1'b0;
        tick(3);
        check("aud_off", aud_pwr, 1'b0);
        aud_ok <= 1'b1;
        tick(3);
        check("aud_on", aud_pwr, 1'b1);
        check("fetches", 16'(fetches), 16'h0001);
        tamp_n <= 1'b0;
        for (i = 0; i < 10 && fail !== 1'b1; i++) tick(1);
        check("fail", {fail, buzz}, 2'b11);
        check("vid_fail", vpass, 11'h000);
        key(1'b0);
        reg_rd(REG_STATUS, 8'h23);
        tamp_n <= 1'b1;
        tick(5);
        check("fail_hold", fail, 1'b1);
        rst_n <= 1'b0;
        btn_n <= 4'b1110;
        tick(2);
        rst_n <= 1'b1;
        for (i = 0; i < PC + 20 && fail !== 1'b1; i++) tick(1);
        reg_rd(REG_STATUS, 8'h10);
        btn_n <= 4'hF;
        tick(3);
        give_verdict();
    end
endmodule
`default_nettype wire
